/* include/fpi_pkg.sv */
// Shared types and constants for the floating-point pipeline interlock.
// Assumes one core clock; the issue logic and load/store pipe sit outside.
package fpi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int FPI_REG_W = 5;
  localparam int FPI_NREG = 32;
  localparam int FPI_CRF_W = 3;
  localparam int FPI_NCRF = 8;
  localparam int FPI_EXC_W = 5;
  localparam int FPI_NUM_EXEC = 4;

  // Stage slots: four execution stages, then the write stage
  localparam int FPI_STG_F1 = 0;
  localparam int FPI_STG_F3 = 2;
  localparam int FPI_STG_F4 = 3;
  localparam int FPI_STG_FW = FPI_NUM_EXEC;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle counts
  localparam logic [7:0] FPI_DIVD_CYC = 8'h22;      // 34: double divide interval
  localparam logic [7:0] FPI_DIVS_CYC = 8'h14;      // 20: single divide interval
  localparam logic [7:0] FPI_DIV_LAST = 8'h01;
  localparam logic [4:0] FPI_NORM_MAX = 5'h17;      // 23 one-bit shifts at most
  localparam logic [4:0] FPI_NORM_LAST = 5'h01;
  localparam logic [2:0] FPI_MISP_FCMP_CYC = 3'h6;  // Penalty beside a compare
  localparam logic [2:0] FPI_MISP_PLAIN_CYC = 3'h1;
  localparam logic [2:0] FPI_MISP_LAST = 3'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Register port map and fields
  localparam logic [7:0] FPI_ADDR_MODE = 8'h00;
  localparam logic [7:0] FPI_ADDR_STATUS = 8'h04;
  localparam int FPI_MODE_PERMIT_BIT = 0;
  localparam int FPI_MODE_EXC_LSB = 1;
  localparam int FPI_MODE_NI_BIT = 6;
  localparam logic FPI_PERMIT_RST = 1'b0;
  localparam logic [FPI_EXC_W-1:0] FPI_EXC_RST = 5'h00;
  localparam logic FPI_NI_RST = 1'b0;
  localparam int FPI_ST_DIV_BUSY = 0;
  localparam int FPI_ST_DIV_ASYNC = 1;
  localparam int FPI_ST_NORM = 2;
  localparam int FPI_ST_MHOLD = 3;
  localparam int FPI_ST_STALL = 4;
  localparam int FPI_ST_STG_LSB = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Operation classes and carriers
  typedef enum logic [2:0] {
    FPI_OP_ARITH, FPI_OP_DMUL, FPI_OP_CMP, FPI_OP_DIVD, FPI_OP_DIVS, FPI_OP_LOAD,
    FPI_OP_STORE
  } fpi_op_t;

  typedef enum logic [1:0] {FPI_DIV_IDLE, FPI_DIV_ASYNC, FPI_DIV_SYNC} fpi_div_st_t;

  typedef struct packed {
    logic valid;
    fpi_op_t op;
    logic [FPI_REG_W-1:0] dst;
    logic [FPI_REG_W-1:0] src_a;
    logic [FPI_REG_W-1:0] src_b;
    logic [FPI_REG_W-1:0] src_c;
    logic [2:0] src_use;
    logic rc;
    logic [FPI_CRF_W-1:0] crf;
  } fpi_issue_t;

  typedef struct packed {
    logic valid;
    fpi_op_t op;
    logic [FPI_REG_W-1:0] dst;
    logic sets_cr;
    logic [FPI_CRF_W-1:0] crf;
    logic sync;
  } fpi_uop_t;

  typedef struct packed {
    logic valid;
    logic [FPI_REG_W-1:0] dst;
    logic single;
    logic zero;
    logic [4:0] shifts;
  } fpi_ldw_t;

endpackage : fpi_pkg

/* src/fpi_interlock.sv */
// Floating-point pipeline interlock: stage tracking, scoreboard, divider,
// load normalization stalls, store holds, branch and exception alignment.
// Assumes issue logic and load/store pipe obey the handshakes below.
//
// Contract
// - Four execution stages lie between decode and the fp write stage.
// - Unstalled fp ops write one cycle after same-group integer ops.
// - Double multiplies hold stage one two cycles; next fp issue waits.
// - Divide results never forwarded; read from register file after write.
// - Async divide needs no enabled exceptions, clear record bit, permit set.
// - Sync divide stalls the whole pipeline until the result is produced.
// - Branch on fp-set condition field resolves no earlier than its write.
// - Mispredict grouped with fp compare waits six cycles before refetch.
// - Fp loads forward one cycle later than fixed loads, no sliding.
// - Denormal single loads normalize one bit per cycle, stalling all.
// - Single-precision zero loads forward one cycle late; issue unaffected.
// - Store data comes only from register file; store holds in cache stage.
// - Denormal single stores take no extra cycles.
// - Enabled exceptions or record bit stall the group in memory stage.
// - Fp and integer pipes advance independently of each other's stalls.
// - Unstalled groups move in lockstep; fp continues to its write stage.
// - Flagged groups align memory stage with stage four, one stall minimum.
// - Plain compare condition updates align at stage three, no stall.
// - Bandwidth is issue spacing; latency is cycles to a usable result.
`timescale 1ns/1ps
`default_nettype none

module fpi_interlock import fpi_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire fpi_issue_t iss,
  output logic iss_ready,
  input wire fpi_ldw_t ld_w,
  input wire logic st_c_valid,
  input wire logic [FPI_REG_W-1:0] st_c_src,
  output logic st_c_hold,
  input wire logic br_valid,
  input wire logic [FPI_CRF_W-1:0] br_crf,
  output logic br_resolve_ok,
  input wire logic br_mispredict,
  input wire logic br_with_fcmp,
  output logic fetch_restart,
  input wire logic int_m_fp_grp,
  output logic int_m_hold,
  output logic exc_check,
  output logic pipe_stall,
  output logic fp_wr_valid,
  output logic [FPI_REG_W-1:0] fp_wr_dst,
  output logic div_wr,
  output logic [FPI_REG_W-1:0] div_wr_dst
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [FPI_NREG-1:0] fpi_reg_mask(input logic [FPI_REG_W-1:0] r,
                                                       input logic en);
    logic [FPI_NREG-1:0] m;
    m = '0;
    m[r] = en;
    return m;
  endfunction : fpi_reg_mask

  function automatic logic [FPI_NCRF-1:0] fpi_cr_mask(input logic [FPI_CRF_W-1:0] f,
                                                      input logic en);
    logic [FPI_NCRF-1:0] m;
    m = '0;
    m[f] = en;
    return m;
  endfunction : fpi_cr_mask

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic permit_r;
  logic [FPI_EXC_W-1:0] exc_en_r;
  logic ni_r;
  logic [31:0] reg_rdata_r;
  fpi_uop_t stg_r [0:FPI_STG_FW];
  logic f1_second_r;
  fpi_div_st_t div_st_r;
  logic [7:0] div_cnt_r;
  logic [FPI_REG_W-1:0] div_dst_r;
  logic div_wr_r;
  logic div_late_r;
  logic [4:0] norm_cnt_r;
  logic [FPI_REG_W-1:0] norm_dst_r;
  logic zero_dly_r;
  logic [FPI_REG_W-1:0] zero_dst_r;
  logic [FPI_NREG-1:0] fwd_pend_r;
  logic [FPI_NREG-1:0] rf_pend_r;
  logic [FPI_NCRF-1:0] cr_pend_r;
  logic [2:0] misp_cnt_r;
  logic fetch_restart_r;

  logic gstall;
  logic dmul_hold;
  logic div_done;
  logic async_wr_hold;
  logic ld_denorm;
  logic ld_plain;
  logic ld_zero;
  logic norm_done;
  logic [FPI_NREG-1:0] fwd_eff;
  logic src_hz;
  logic dst_hz;
  logic is_div;
  logic is_pipe_op;
  logic iss_fire;
  logic flagged;
  logic flag_upstream;
  fpi_uop_t new_uop;

  ////////////////////////////////////////////////////////////////////////////
  // Mode register and read port
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      permit_r <= FPI_PERMIT_RST;
      exc_en_r <= FPI_EXC_RST;
      ni_r <= FPI_NI_RST;
    end else if (reg_wr && reg_addr == FPI_ADDR_MODE) begin
      permit_r <= reg_wdata[FPI_MODE_PERMIT_BIT];
      exc_en_r <= reg_wdata[FPI_MODE_EXC_LSB +: FPI_EXC_W];
      ni_r <= reg_wdata[FPI_MODE_NI_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata_r <= 32'h0;
    end else begin
      reg_rdata_r <= 32'h0;
      if (reg_rd && reg_addr == FPI_ADDR_MODE) begin
        reg_rdata_r[FPI_MODE_PERMIT_BIT] <= permit_r;
        reg_rdata_r[FPI_MODE_EXC_LSB +: FPI_EXC_W] <= exc_en_r;
        reg_rdata_r[FPI_MODE_NI_BIT] <= ni_r;
      end else if (reg_rd && reg_addr == FPI_ADDR_STATUS) begin
        reg_rdata_r[FPI_ST_DIV_BUSY] <= div_st_r != FPI_DIV_IDLE;
        reg_rdata_r[FPI_ST_DIV_ASYNC] <= div_st_r == FPI_DIV_ASYNC;
        reg_rdata_r[FPI_ST_NORM] <= norm_cnt_r != 5'h0;
        reg_rdata_r[FPI_ST_MHOLD] <= int_m_hold;
        reg_rdata_r[FPI_ST_STALL] <= gstall;
        for (int i = 0; i <= FPI_STG_FW; i++) begin
          reg_rdata_r[FPI_ST_STG_LSB + i] <= stg_r[i].valid;
        end
      end
    end
  end

  assign reg_rdata = reg_rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Issue decision
  assign gstall = (div_st_r == FPI_DIV_SYNC) || (norm_cnt_r != 5'h0);
  assign dmul_hold = stg_r[FPI_STG_F1].valid && stg_r[FPI_STG_F1].op == FPI_OP_DMUL &&
                     !f1_second_r;
  assign div_done = div_st_r != FPI_DIV_IDLE && div_cnt_r == FPI_DIV_LAST;
  // Divider steals the write port in its last cycle
  assign async_wr_hold = div_st_r == FPI_DIV_ASYNC && div_cnt_r == FPI_DIV_LAST;

  // Non-IEEE mode flushes denormals, so no normalization stall
  assign ld_denorm = ld_w.valid && ld_w.single && ld_w.shifts != 5'h0 && !ni_r && !gstall;
  assign ld_zero = ld_w.valid && ld_w.single && ld_w.zero && !ld_denorm && !gstall;
  assign ld_plain = ld_w.valid && !ld_denorm && !ld_zero && !gstall;
  assign norm_done = norm_cnt_r == FPI_NORM_LAST;

  // Plain loads forward in their write cycle, a cycle after fixed loads
  // Zero loads forward from the delayed copy, one cycle after a plain load
  assign fwd_eff = fwd_pend_r & ~fpi_reg_mask(ld_w.dst, ld_plain)
                   & ~fpi_reg_mask(zero_dst_r, zero_dly_r);

  assign is_div = iss.op == FPI_OP_DIVD || iss.op == FPI_OP_DIVS;
  assign is_pipe_op = iss.op == FPI_OP_ARITH || iss.op == FPI_OP_DMUL ||
                      iss.op == FPI_OP_CMP;

  always_comb begin
    src_hz = 1'b0;
    if (iss.op != FPI_OP_LOAD && iss.op != FPI_OP_STORE) begin
      src_hz = (iss.src_use[0] && fwd_eff[iss.src_a]) ||
               (iss.src_use[1] && fwd_eff[iss.src_b]) ||
               (iss.src_use[2] && fwd_eff[iss.src_c]);
    end
  end

  assign dst_hz = iss.op != FPI_OP_STORE && iss.op != FPI_OP_CMP && fwd_eff[iss.dst];

  assign iss_ready = !gstall && !dmul_hold && !async_wr_hold && !src_hz && !dst_hz &&
                     !(is_div && div_st_r != FPI_DIV_IDLE);
  assign iss_fire = iss.valid && iss_ready;

  // Any enabled exception or a record bit forces memory-stage alignment
  assign flagged = iss.rc || (exc_en_r != FPI_EXC_RST);

  always_comb begin
    new_uop = '0;
    new_uop.valid = iss_fire && is_pipe_op;
    new_uop.op = iss.op;
    new_uop.dst = iss.dst;
    new_uop.sets_cr = iss.op == FPI_OP_CMP || iss.rc;
    new_uop.crf = iss.crf;
    new_uop.sync = flagged;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Execution stages: independent of integer holds
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i <= FPI_STG_FW; i++) begin
        stg_r[i] <= '0;
      end
      f1_second_r <= 1'b0;
    end else if (!gstall) begin
      if (dmul_hold) begin
        f1_second_r <= 1'b1;
        stg_r[FPI_STG_F1 + 1] <= '0;
      end else begin
        f1_second_r <= 1'b0;
        stg_r[FPI_STG_F1] <= new_uop;
        stg_r[FPI_STG_F1 + 1] <= stg_r[FPI_STG_F1];
      end
      for (int i = FPI_STG_F1 + 2; i <= FPI_STG_FW; i++) begin
        stg_r[i] <= stg_r[i-1];
      end
    end
  end

  assign fp_wr_valid = stg_r[FPI_STG_FW].valid && stg_r[FPI_STG_FW].op != FPI_OP_CMP;
  assign fp_wr_dst = stg_r[FPI_STG_FW].dst;
  assign pipe_stall = gstall;
  assign exc_check = stg_r[FPI_STG_F4].valid && stg_r[FPI_STG_F4].sync;

  always_comb begin
    flag_upstream = 1'b0;
    for (int i = FPI_STG_F1; i <= FPI_STG_F3; i++) begin
      flag_upstream = flag_upstream || (stg_r[i].valid && stg_r[i].sync);
    end
  end

  // Unflagged compares meet memory at stage three and never hold
  assign int_m_hold = int_m_fp_grp && flag_upstream;

  ////////////////////////////////////////////////////////////////////////////
  // Divider
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_st_r <= FPI_DIV_IDLE;
      div_cnt_r <= 8'h0;
      div_dst_r <= '0;
    end else if (iss_fire && is_div) begin
      div_cnt_r <= iss.op == FPI_OP_DIVD ? FPI_DIVD_CYC : FPI_DIVS_CYC;
      div_dst_r <= iss.dst;
      if (exc_en_r == FPI_EXC_RST && !iss.rc && permit_r) begin
        div_st_r <= FPI_DIV_ASYNC;
      end else begin
        div_st_r <= FPI_DIV_SYNC;
      end
    end else if (div_st_r != FPI_DIV_IDLE) begin
      div_cnt_r <= div_cnt_r - FPI_DIV_LAST;
      if (div_done) begin
        div_st_r <= FPI_DIV_IDLE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_wr_r <= 1'b0;
      div_late_r <= 1'b0;
    end else begin
      div_wr_r <= div_done;
      // Async result is written, then read back a cycle later
      div_late_r <= div_done && div_st_r == FPI_DIV_ASYNC;
    end
  end

  assign div_wr = div_wr_r;
  assign div_wr_dst = div_dst_r;

  ////////////////////////////////////////////////////////////////////////////
  // Load normalization and zero check
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      norm_cnt_r <= 5'h0;
      norm_dst_r <= '0;
    end else if (ld_denorm) begin
      norm_cnt_r <= ld_w.shifts > FPI_NORM_MAX ? FPI_NORM_MAX : ld_w.shifts;
      norm_dst_r <= ld_w.dst;
    end else if (norm_cnt_r != 5'h0) begin
      norm_cnt_r <= norm_cnt_r - FPI_NORM_LAST;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      zero_dly_r <= 1'b0;
      zero_dst_r <= '0;
    end else begin
      zero_dly_r <= ld_zero;
      zero_dst_r <= ld_w.dst;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scoreboards; a set in the same cycle as a clear wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fwd_pend_r <= '0;
    end else begin
      fwd_pend_r <= (fwd_pend_r
                     & ~fpi_reg_mask(stg_r[FPI_STG_F3].dst, !gstall &&
                                     stg_r[FPI_STG_F3].valid)
                     & ~fpi_reg_mask(ld_w.dst, ld_plain)
                     & ~fpi_reg_mask(zero_dst_r, zero_dly_r)
                     & ~fpi_reg_mask(norm_dst_r, norm_done)
                     & ~fpi_reg_mask(div_dst_r, div_done && div_st_r == FPI_DIV_SYNC)
                     & ~fpi_reg_mask(div_dst_r, div_late_r))
                    | fpi_reg_mask(iss.dst, iss_fire && iss.op != FPI_OP_STORE &&
                                   iss.op != FPI_OP_CMP);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rf_pend_r <= '0;
    end else begin
      rf_pend_r <= (rf_pend_r
                    & ~fpi_reg_mask(stg_r[FPI_STG_FW].dst, !gstall && fp_wr_valid)
                    & ~fpi_reg_mask(ld_w.dst, ld_plain || ld_zero)
                    & ~fpi_reg_mask(norm_dst_r, norm_done)
                    & ~fpi_reg_mask(div_dst_r, div_done))
                   | fpi_reg_mask(iss.dst, iss_fire && iss.op != FPI_OP_STORE &&
                                  iss.op != FPI_OP_CMP);
    end
  end

  // Store waits for the register write; denormal stores get no extra hold
  assign st_c_hold = st_c_valid && rf_pend_r[st_c_src];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cr_pend_r <= '0;
    end else begin
      cr_pend_r <= (cr_pend_r & ~fpi_cr_mask(stg_r[FPI_STG_F4].crf, !gstall &&
                                             stg_r[FPI_STG_F4].valid &&
                                             stg_r[FPI_STG_F4].sets_cr))
                   | fpi_cr_mask(iss.crf, new_uop.valid && new_uop.sets_cr);
    end
  end

  assign br_resolve_ok = br_valid && !cr_pend_r[br_crf];

  ////////////////////////////////////////////////////////////////////////////
  // Mispredict refetch timer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      misp_cnt_r <= 3'h0;
      fetch_restart_r <= 1'b0;
    end else begin
      fetch_restart_r <= misp_cnt_r == FPI_MISP_LAST;
      if (br_mispredict) begin
        misp_cnt_r <= br_with_fcmp ? FPI_MISP_FCMP_CYC : FPI_MISP_PLAIN_CYC;
      end else if (misp_cnt_r != 3'h0) begin
        misp_cnt_r <= misp_cnt_r - FPI_MISP_LAST;
      end
    end
  end

  assign fetch_restart = fetch_restart_r;

endmodule : fpi_interlock

`default_nettype wire

/* dv/fpi_assertions.sv */
// Port checker for the fp pipeline interlock.
// Assumes bench traffic keeps to the issue and register contracts.
`timescale 1ns/1ps
`default_nettype none
module fpi_assertions import fpi_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire fpi_issue_t iss,
  input wire logic iss_ready,
  input wire fpi_ldw_t ld_w,
  input wire logic br_mispredict,
  input wire logic br_with_fcmp,
  input wire logic fetch_restart,
  input wire logic int_m_fp_grp,
  input wire logic int_m_hold,
  input wire logic pipe_stall,
  input wire logic fp_wr_valid,
  input wire logic [FPI_REG_W-1:0] fp_wr_dst,
  input wire logic div_wr,
  input wire logic [FPI_REG_W-1:0] div_wr_dst
);
  logic [6:0] mode_r;
  logic acc;
  assign acc = iss.valid && iss_ready;
  // Shadow of the mode fields, so antecedents know the divider mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_r <= 7'h00;
    end else if (reg_wr && reg_addr == FPI_ADDR_MODE) begin
      mode_r <= reg_wdata[6:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  //////////////////////////////
  AST_FP_WR: assert property (acc && iss.op == FPI_OP_ARITH ##1 !pipe_stall [*4]
    |=> fp_wr_valid && fp_wr_dst == $past(iss.dst, 5))
    else $error("fp write not five cycles after issue");
  AST_DMUL_GAP: assert property (acc && iss.op == FPI_OP_DMUL |=> !iss_ready)
    else $error("issue taken right after a double multiply");
  AST_SYNC_DIV: assert property (acc && iss.op == FPI_OP_DIVS && iss.rc |=> pipe_stall [*8])
    else $error("sync divide did not stall the pipe");
  AST_DIV_LAT: assert property (acc && iss.op == FPI_OP_DIVD && iss.rc |-> ##35
    div_wr && div_wr_dst == $past(iss.dst, 35))
    else $error("double divide write misplaced");
  AST_ASYNC: assert property (acc && iss.op == FPI_OP_DIVS && !iss.rc
    && mode_r[5:0] == 6'h01 |=> !pipe_stall)
    else $error("async divide stalled the pipe");
  AST_NO_ISS: assert property (pipe_stall |-> !iss_ready)
    else $error("issue accepted during stall");
  AST_NORM: assert property (ld_w.valid && !pipe_stall && ld_w.single && ld_w.shifts == 5'h03
    && !mode_r[6] |=> pipe_stall [*3] ##1 !pipe_stall)
    else $error("normalization stall length wrong");
  AST_MISP6: assert property (br_mispredict && br_with_fcmp ##1 !br_mispredict [*6]
    |=> fetch_restart)
    else $error("compare mispredict restart not at seven");
  AST_MISP1: assert property (br_mispredict && !br_with_fcmp ##1 !br_mispredict
    |=> fetch_restart)
    else $error("plain mispredict restart late");
  AST_HOLD: assert property (acc && iss.op == FPI_OP_ARITH && iss.rc ##1 int_m_fp_grp
    |-> int_m_hold)
    else $error("flagged group not held at memory stage");
endmodule : fpi_assertions
bind fpi_interlock fpi_assertions i_fpi_assertions (.clk, .sys_rst, .reg_addr, .reg_wdata,
  .reg_wr, .iss, .iss_ready, .ld_w, .br_mispredict, .br_with_fcmp, .fetch_restart,
  .int_m_fp_grp, .int_m_hold, .pipe_stall, .fp_wr_valid, .fp_wr_dst, .div_wr, .div_wr_dst);
`default_nettype wire

/* dv/fpi_partner.sv */
// Issue-side model: queues requests, presents them in order.
// Assumes pushes come from the bench one per edge.
`timescale 1ns/1ps
`default_nettype none
module fpi_partner import fpi_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic push,
  input wire fpi_issue_t nxt,
  input wire logic gate,
  input wire logic iss_ready,
  output fpi_issue_t iss
);
  fpi_issue_t q[$];
  // Head held until taken; multiply spacing left to the interlock's iss_ready
  always @(posedge clk) begin
    if (sys_rst) begin
      q.delete();
      iss <= '0;
    end else begin
      if (iss.valid && iss_ready) begin
        void'(q.pop_front());
      end
      if (push) begin
        q.push_back(nxt);
      end
      if (gate && q.size() > 0) begin
        iss <= q[0];
      end else begin
        // Idle fields toggle so stale values never look valid
        iss <= fpi_issue_t'({1'b0, ~iss[$bits(fpi_issue_t)-2:0]});
      end
    end
  end
endmodule : fpi_partner
`default_nettype wire

/* dv/tb.sv */
// Self-checking bench for the fp pipeline interlock.
// Assumes the interlock, checker and issue model are compiled.
`timescale 1ns/1ps
`default_nettype none
module tb import fpi_pkg::*;;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, push = 1'b0, gate = 1'b0, st_c_valid = 1'b0;
  logic br_valid = 1'b0, br_mispredict = 1'b0, br_with_fcmp = 1'b0, int_m_fp_grp = 1'b0;
  logic [4:0] st_c_src = 5'h00;
  logic [2:0] br_crf = 3'h0;
  fpi_issue_t nxt = '0, iss;
  fpi_ldw_t ld_w = '0;
  logic [31:0] reg_rdata;
  logic iss_ready, st_c_hold, br_resolve_ok, fetch_restart, int_m_hold, exc_check;
  logic pipe_stall, fp_wr_valid, div_wr;
  logic [4:0] fp_wr_dst, div_wr_dst;
  int errors = 0, checks = 0, cyc = 0, nstall = 0, nhold = 0, fr_c = 0, dw_c = 0, exc_c = 0;
  int acc[$], wr_c[$];
  fpi_interlock i_fpi_interlock (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .iss, .iss_ready, .ld_w, .st_c_valid, .st_c_src, .st_c_hold, .br_valid,
    .br_crf, .br_resolve_ok, .br_mispredict, .br_with_fcmp, .fetch_restart, .int_m_fp_grp,
    .int_m_hold, .exc_check, .pipe_stall, .fp_wr_valid, .fp_wr_dst, .div_wr, .div_wr_dst);
  fpi_partner i_fpi_partner (.clk, .sys_rst, .push, .nxt, .gate, .iss_ready, .iss);
  initial forever #2.5 clk = ~clk;
  //////////////////////////////
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      conclude();
    end
  end
  // Event log 1 ns after the edge, so it always lands before the tasks' negedge checks
  always @(posedge clk) begin
    #1;
    if (iss.valid && iss_ready) acc.push_back(cyc);
    if (fp_wr_valid) wr_c.push_back(cyc);
    if (pipe_stall) nstall++;
    if (int_m_hold) nhold++;
    if (fetch_restart) fr_c = cyc;
    if (div_wr) dw_c = cyc;
    if (exc_check) exc_c = cyc;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, e);
  endtask : rd
  task automatic put(input fpi_op_t op, input logic [4:0] d, input logic [4:0] a,
                     input logic rc, input logic [2:0] f);
    @(posedge clk);
    push <= 1'b1;
    nxt <= '{valid: 1'b1, op: op, dst: d, src_a: a, src_b: 5'h00, src_c: 5'h00,
             src_use: {2'b00, a != 5'h00}, rc: rc, crf: f};
    @(posedge clk);
    push <= 1'b0;
  endtask : put
  task automatic go(input int n);
    acc.delete();
    wr_c.delete();
    @(posedge clk);
    gate <= 1'b1;
    for (int i = 0; i < 200 && acc.size() < n; i++) @(negedge clk);
    chk(acc.size(), n);
    @(posedge clk);
    gate <= 1'b0;
  endtask : go
  //////////////////////////////
  task automatic t_regs();
    rd(FPI_ADDR_MODE, 32'h0);
    rd(FPI_ADDR_STATUS, 32'h0);
    wr(FPI_ADDR_MODE, 32'h41);
    wr(FPI_ADDR_STATUS, 32'hFF);
    rd(FPI_ADDR_MODE, 32'h41);
    rd(8'h08, 32'h0);
    wr(FPI_ADDR_MODE, 32'h0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_arith();
    @(posedge clk);
    st_c_valid <= 1'b1;
    st_c_src <= 5'h02;
    put(FPI_OP_ARITH, 5'h01, 5'h00, 1'b0, 3'h0);
    put(FPI_OP_ARITH, 5'h02, 5'h01, 1'b0, 3'h0);
    go(2);
    chk(acc[1] - acc[0], 4);
    repeat (5) @(negedge clk);
    chk(st_c_hold, 1);
    @(negedge clk);
    chk(st_c_hold, 0);
    chk(wr_c[0] - acc[0], 5);
    chk(wr_c[1] - acc[1], 5);
    @(posedge clk);
    st_c_valid <= 1'b0;
    $display("test arith done");
  endtask : t_arith
  task automatic t_dmul();
    put(FPI_OP_DMUL, 5'h03, 5'h00, 1'b0, 3'h0);
    put(FPI_OP_DMUL, 5'h04, 5'h00, 1'b0, 3'h0);
    put(FPI_OP_ARITH, 5'h05, 5'h00, 1'b0, 3'h0);
    go(3);
    chk(acc[1] - acc[0], 2);
    chk(acc[2] - acc[1], 2);
    repeat (8) @(negedge clk);
    chk(wr_c[0] - acc[0], 6);
    $display("test dmul done");
  endtask : t_dmul
  task automatic misp(input logic w, input int n);
    int t;
    @(posedge clk);
    br_mispredict <= 1'b1;
    br_with_fcmp <= w;
    @(negedge clk);
    t = cyc;
    @(posedge clk);
    br_mispredict <= 1'b0;
    repeat (9) @(negedge clk);
    chk(fr_c - t, n);
  endtask : misp
  task automatic t_cmp();
    @(posedge clk);
    br_valid <= 1'b1;
    br_crf <= 3'h1;
    int_m_fp_grp <= 1'b1;
    nhold = 0;
    put(FPI_OP_CMP, 5'h00, 5'h00, 1'b0, 3'h1);
    go(1);
    repeat (4) @(negedge clk);
    chk(br_resolve_ok, 0);
    @(negedge clk);
    chk(br_resolve_ok, 1);
    chk(nhold, 0);
    misp(1'b1, 7);
    misp(1'b0, 2);
    $display("test compare done");
  endtask : t_cmp
  task automatic flag(input logic rc, input logic [31:0] m);
    wr(FPI_ADDR_MODE, m);
    nhold = 0;
    put(FPI_OP_ARITH, 5'h07, 5'h00, rc, 3'h2);
    go(1);
    repeat (6) @(negedge clk);
    chk(nhold, 3);
    chk(exc_c - acc[0], 4);
    chk(wr_c[0] - acc[0], 5);
    wr(FPI_ADDR_MODE, 32'h0);
    $display("test flagged done");
  endtask : flag
  task automatic div(input fpi_op_t op, input logic rc, input logic [31:0] m,
                     input int st, input int lat);
    wr(FPI_ADDR_MODE, m);
    nstall = 0;
    put(op, 5'h09, 5'h00, rc, 3'h0);
    put(FPI_OP_ARITH, 5'h0A, 5'h09, 1'b0, 3'h0);
    go(2);
    repeat (3) @(negedge clk);
    chk(nstall, st);
    chk(acc[1] - dw_c, lat);
    if (st != 0) chk(dw_c - acc[0], st + 1);
    wr(FPI_ADDR_MODE, 32'h0);
    $display("test divide done");
  endtask : div
  task automatic ld(input logic s, input logic z, input logic [4:0] sh, input int st,
                    input int dep, input logic [31:0] m);
    int t;
    wr(FPI_ADDR_MODE, m);
    put(FPI_OP_LOAD, 5'h0C, 5'h00, 1'b0, 3'h0);
    go(1);
    put(FPI_OP_ARITH, 5'h0D, 5'h0C, 1'b0, 3'h0);
    @(posedge clk);
    gate <= 1'b1;
    acc.delete();
    repeat (3) @(posedge clk);
    nstall = 0;
    ld_w <= '{valid: 1'b1, dst: 5'h0C, single: s, zero: z, shifts: sh};
    @(negedge clk);
    t = cyc;
    @(posedge clk);
    ld_w <= {1'b0, ~ld_w[11:0]};
    for (int i = 0; i < 60 && acc.size() < 1; i++) @(negedge clk);
    chk(nstall, st);
    if (dep >= 0) chk(acc[0] - t, dep);
    @(posedge clk);
    gate <= 1'b0;
    wr(FPI_ADDR_MODE, 32'h0);
    $display("test load done");
  endtask : ld
  task automatic conclude();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  //////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_arith();
    t_dmul();
    t_cmp();
    flag(1'b1, 32'h0);
    flag(1'b0, 32'h2);
    div(FPI_OP_DIVS, 1'b1, 32'h0, 20, 0);
    div(FPI_OP_DIVD, 1'b1, 32'h0, 34, 0);
    div(FPI_OP_DIVS, 1'b0, 32'h0, 20, 0);
    div(FPI_OP_DIVS, 1'b0, 32'h3, 20, 0);
    div(FPI_OP_DIVS, 1'b0, 32'h1, 0, 1);
    ld(1'b0, 1'b0, 5'h00, 0, 0, 32'h0);
    ld(1'b1, 1'b1, 5'h00, 0, 1, 32'h0);
    ld(1'b1, 1'b0, 5'h03, 3, 4, 32'h0);
    ld(1'b1, 1'b0, 5'h1F, 23, 24, 32'h0);
    ld(1'b1, 1'b0, 5'h03, 0, -1, 32'h40);
    conclude();
  end
endmodule : tb
`default_nettype wire
